// file: hdl/io_window_decode.sv
`timescale 1ns/1ps
module io_window_decode (
	input wire logic [2:0] window_code,
	output logic [9:0] window_base_addr
);
	import second_uart_pkg::*;
	// table lookup of the eight-byte window base
	always_comb begin
		window_base_addr = window_base[window_code];
	end
endmodule

// file: hdl/second_uart_pkg.sv
package second_uart_pkg;
	// ----------------------------------------
	// register map (wishbone word addresses)
	// ----------------------------------------
	localparam logic [3:0] setup_addr = 4'h0;
	localparam logic [3:0] status_addr = 4'h4;
	localparam logic [3:0] first_port_addr = 4'h8;
	localparam int addr_w = 4;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int music_bit = 7;
	localparam int irq_bit = 4;
	localparam int win_lo = 1;
	localparam int win_hi = 3;
	localparam int enable_bit = 0;
	localparam logic [7:0] writable_mask = 8'h9f;

	// ----------------------------------------
	// reset values and configuration modes
	// ----------------------------------------
	localparam logic [7:0] setup_soft_reset = 8'h00;
	localparam logic [2:0] window_reset = 3'h0;

	typedef enum logic [1:0] {
		hardware_basic_config_mode = 2'h0,
		hardware_extended_config_mode = 2'h1,
		software_motherboard_config_mode = 2'h2,
		software_addin_config_mode = 2'h3
	} config_mode_e;

	// ----------------------------------------
	// reference clocks and decode windows
	// ----------------------------------------
	localparam int ref_std_hz = 1846200;
	localparam int ref_music_hz = 2000000;
	localparam logic [9:0] window_base [8] = '{10'h3f8, 10'h2f8, 10'h220, 10'h228,
		10'h238, 10'h2e8, 10'h338, 10'h3e8};
endpackage

// file: hdl/second_uart_setup.sv
`timescale 1ns/1ps
// Contract
// - bit 7 picks 2 MHz over 1.8462 MHz
// - bit 4 routes interrupt to IRQ3/IRQ4
// - bits 3:1 pick eight-byte decode window
// - port operates only while bit 0 set
// - interrupt select: zero in software modes, else strap
// - window select: 000 in software modes, else strap
// - enable: zero in software modes, else strap
// - address clash disables port, no powerdown
// - shared interrupt line is never blocked
// - first port enable bit gates clash check
module second_uart_setup (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [second_uart_pkg::addr_w-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire second_uart_pkg::config_mode_e config_mode,
	input wire logic strap_irq_select,
	input wire logic [2:0] strap_window,
	input wire logic strap_enable,
	input wire logic [2:0] first_port_window,
	input wire logic first_port_irq_select,
	output logic music_rate_clock_select,
	output logic irq3_route,
	output logic irq4_route,
	output logic [9:0] io_window_base,
	output logic second_port_active,
	output logic addr_clash
);
	import second_uart_pkg::*;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0] setup_r;
	logic first_port_enable_r;
	logic strap_done_r;
	logic [9:0] base_nxt;
	logic wb_hit;
	logic clash;
	logic hw_mode;

	// no request is taken while ack stands, so a strobe held into the ack cycle is not answered twice
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign hw_mode = (config_mode == hardware_basic_config_mode) ||
		(config_mode == hardware_extended_config_mode);
	// first port's interrupt choice is not compared: sharing is allowed
	assign clash = setup_r[enable_bit] && first_port_enable_r &&
		(setup_r[win_hi:win_lo] == first_port_window);

	io_window_decode u_decode (
		.window_code(setup_r[win_hi:win_lo]),
		.window_base_addr(base_nxt)
	);

	// ----------------------------------------
	// setup register, straps caught after release
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_r <= setup_soft_reset;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			// straps are caught once; a setup register write in this cycle is acked but lost
			strap_done_r <= 1'b1;
			if (hw_mode) begin
				setup_r[irq_bit] <= strap_irq_select;
				setup_r[win_hi:win_lo] <= strap_window;
				setup_r[enable_bit] <= strap_enable;
			end else begin
				setup_r[irq_bit] <= 1'b0;
				setup_r[win_hi:win_lo] <= window_reset;
				setup_r[enable_bit] <= 1'b0;
			end
		end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == setup_addr) begin
			// reserved bits stay zero
			setup_r <= wb_dat_i[7:0] & writable_mask;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_port_enable_r <= 1'b0;
		end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == first_port_addr) begin
			first_port_enable_r <= wb_dat_i[enable_bit];
		end
	end

	// ----------------------------------------
	// wishbone answer: one wait state, unmapped reads zero
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= 32'h0;
			if (wb_hit && !wb_we_i) begin
				unique case (wb_adr_i)
					setup_addr: wb_dat_o <= {24'h0, setup_r};
					status_addr: wb_dat_o <= {30'h0, clash, setup_r[enable_bit] && !clash};
					first_port_addr: wb_dat_o <= {31'h0, first_port_enable_r};
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// port controls
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			music_rate_clock_select <= 1'b0;
			irq3_route <= 1'b0;
			irq4_route <= 1'b0;
			io_window_base <= 10'h0;
			second_port_active <= 1'b0;
			addr_clash <= 1'b0;
		end else begin
			// every pin trails the register by one cycle so that it comes straight from a flop
			music_rate_clock_select <= setup_r[music_bit];
			irq3_route <= !setup_r[irq_bit] && setup_r[enable_bit];
			irq4_route <= setup_r[irq_bit] && setup_r[enable_bit];
			io_window_base <= base_nxt;
			second_port_active <= setup_r[enable_bit] && !clash;
			addr_clash <= clash;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_music;
		@(posedge core_clk) disable iff (!rst_n) 1'b1 |=> music_rate_clock_select == $past(setup_r[music_bit]);
	endproperty
	a_music: assert property (p_music) else $error("music clock select stale");

	property p_irq;
		@(posedge core_clk) disable iff (!rst_n) $past(setup_r[enable_bit]) |-> (irq4_route == $past(setup_r[irq_bit]))
			&& (irq3_route != irq4_route);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt route wrong");

	property p_window;
		@(posedge core_clk) disable iff (!rst_n) 1'b1 |=>
			io_window_base == window_base[$past(setup_r[win_hi:win_lo])];
	endproperty
	a_window: assert property (p_window) else $error("window base wrong");

	property p_disabled;
		@(posedge core_clk) disable iff (!rst_n) !setup_r[enable_bit] |=> !second_port_active;
	endproperty
	a_disabled: assert property (p_disabled) else $error("port active while disabled");

	property p_soft_defaults;
		@(posedge core_clk) disable iff (!rst_n) (!strap_done_r && !hw_mode) |=> setup_r == setup_soft_reset;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults) else $error("software defaults wrong");

	property p_strap;
		@(posedge core_clk) disable iff (!rst_n) (!strap_done_r && hw_mode) |=>
			setup_r[irq_bit] == $past(strap_irq_select) && setup_r[win_hi:win_lo] == $past(strap_window) &&
			setup_r[enable_bit] == $past(strap_enable);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not loaded");

	property p_clash;
		@(posedge core_clk) disable iff (!rst_n) clash |=> addr_clash && !second_port_active;
	endproperty
	a_clash: assert property (p_clash) else $error("clash did not disable port");

	property p_reserved;
		@(posedge core_clk) disable iff (!rst_n) (setup_r & ~writable_mask) == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set");

	property p_ack;
		@(posedge core_clk) disable iff (!rst_n) wb_hit |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");

	property p_active;
		@(posedge core_clk) disable iff (!rst_n) (setup_r[enable_bit] && !clash) |=> second_port_active;
	endproperty
	a_active: assert property (p_active) else $error("enabled port not active");

	property p_route_off;
		@(posedge core_clk) disable iff (!rst_n) !setup_r[enable_bit] |=> !irq3_route && !irq4_route;
	endproperty
	a_route_off: assert property (p_route_off) else $error("route driven while disabled");

	// choosing the first port's line must still store: sharing is left to software
	property p_shared_irq;
		@(posedge core_clk) disable iff (!rst_n) (strap_done_r && wb_hit && wb_we_i && wb_sel_i[0] &&
			wb_adr_i == setup_addr && wb_dat_i[irq_bit] == first_port_irq_select) |=>
			setup_r[irq_bit] == $past(wb_dat_i[irq_bit]);
	endproperty
	a_shared_irq: assert property (p_shared_irq) else $error("shared interrupt line blocked");

	// ----------------------------------------
	// bus-side checks
	// ----------------------------------------
	property p_first_enable;
		@(posedge core_clk) disable iff (!rst_n) (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == first_port_addr) |=>
			first_port_enable_r == $past(wb_dat_i[enable_bit]);
	endproperty
	a_first_enable: assert property (p_first_enable) else $error("first port enable not stored");

	// read data stand only with ack; between answers the bus sees zero
	property p_idle_data;
		@(posedge core_clk) disable iff (!rst_n) !wb_hit |=> wb_dat_o == 32'h0;
	endproperty
	a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
endmodule

// file: testbench/test_second_uart_setup.sv
`timescale 1ns/1ps
module test_second_uart_setup;
	import second_uart_pkg::*;
	logic core_clk = 0;
	logic rst_n = 0;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, music_rate_clock_select, irq3_route, irq4_route, second_port_active, addr_clash;
	logic [9:0] io_window_base;
	config_mode_e config_mode = software_motherboard_config_mode;
	logic strap_irq_select = 0, strap_enable = 0, first_port_irq_select = 0;
	logic [2:0] strap_window = 3'h0, first_port_window = 3'h7;
	logic [7:0] rd;
	logic [9:0] exp_win [8] = '{10'h3f8, 10'h2f8, 10'h220, 10'h228, 10'h238, 10'h2e8, 10'h338, 10'h3e8};
	int fails = 0, cmp_count = 0;
	always #50 core_clk = ~core_clk;
	second_uart_setup u_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .config_mode(config_mode), .strap_irq_select(strap_irq_select),
		.strap_window(strap_window), .strap_enable(strap_enable), .first_port_window(first_port_window),
		.first_port_irq_select(first_port_irq_select), .music_rate_clock_select(music_rate_clock_select),
		.irq3_route(irq3_route), .irq4_route(irq4_route), .io_window_base(io_window_base),
		.second_port_active(second_port_active), .addr_clash(addr_clash));
	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask
	// ack is read just after the edge, before the design's update, so it is the value that edge sampled
	task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'h1;
		wb_adr_i <= adr;
		wb_dat_i <= {24'h0, d};
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (wb_ack_o === 1'b1) break;
		end
		if (n == 20) begin
			fails++;
			wrap_up();
		end
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			@(posedge core_clk);
			rst_n <= 1'b0;
			config_mode <= config_mode_e'(m);
			strap_irq_select <= 1'b1;
			strap_window <= 3'h5;
			strap_enable <= 1'b1;
			repeat (12) @(posedge core_clk);
			rst_n <= 1'b1;
			repeat (3) @(posedge core_clk);
			bus(1'b0, setup_addr, 8'h0, rd);
			chk("setup after reset", (m < 2) ? 10'h01b : 10'h000, {2'b00, rd});
		end
		$display("test modes done");
	endtask
	task automatic t_fields();
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, setup_addr, {4'hf, i[2:0], 1'b1}, rd);
			bus(1'b0, setup_addr, 8'h0, rd);
			chk("setup readback", {2'b00, 4'h9, i[2:0], 1'b1}, {2'b00, rd});
			repeat (3) @(negedge core_clk);
			chk("window base", exp_win[i], io_window_base);
			chk("music clock", 10'h1, {9'h0, music_rate_clock_select});
			chk("irq routes", 10'h2, {8'h0, irq4_route, irq3_route});
			chk("active", 10'h1, {9'h0, second_port_active});
		end
		bus(1'b1, setup_addr, 8'h03, rd);
		repeat (3) @(negedge core_clk);
		chk("irq3 route", 10'h1, {8'h0, irq4_route, irq3_route});
		chk("music off", 10'h0, {9'h0, music_rate_clock_select});
		bus(1'b1, setup_addr, 8'h02, rd);
		repeat (3) @(negedge core_clk);
		chk("disabled", 10'h0, {7'h0, irq4_route, irq3_route, second_port_active});
		bus(1'b1, status_addr, 8'hff, rd);
		bus(1'b0, setup_addr, 8'h0, rd);
		chk("status write dropped", 10'h002, {2'b00, rd});
		$display("test fields done");
	endtask
	task automatic t_clash();
		@(posedge core_clk);
		first_port_window <= 3'h2;
		first_port_irq_select <= 1'b1;
		bus(1'b1, first_port_addr, 8'h01, rd);
		bus(1'b0, first_port_addr, 8'h0, rd);
		chk("first port enable", 10'h1, {2'b00, rd});
		bus(1'b1, setup_addr, 8'h15, rd);
		repeat (3) @(negedge core_clk);
		chk("clash", 10'h1, {9'h0, addr_clash});
		chk("active in clash", 10'h0, {9'h0, second_port_active});
		bus(1'b0, status_addr, 8'h0, rd);
		chk("status in clash", 10'h2, {2'b00, rd});
		bus(1'b0, setup_addr, 8'h0, rd);
		chk("shared irq kept", 10'h15, {2'b00, rd});
		bus(1'b1, first_port_addr, 8'h00, rd);
		repeat (3) @(negedge core_clk);
		chk("clash gone", 10'h1, {8'h0, addr_clash, second_port_active});
		chk("irq4 shared", 10'h2, {8'h0, irq4_route, irq3_route});
		bus(1'b0, 4'hc, 8'h0, rd);
		chk("unmapped read", 10'h0, {2'b00, rd});
		$display("test clash done");
	endtask
	initial begin
		t_modes();
		t_fields();
		t_clash();
		wrap_up();
	end
endmodule
